// ===== smwc_defs.svh
// Constants for the power switch mode, serial and watchdog control
`ifndef SMWC_DEFS_SVH
`define SMWC_DEFS_SVH

// ************************************************************
// Serial frame
// ************************************************************
`define SMWC_FRAME_BITS  4'h8
`define SMWC_BITCNT_MAX  4'hF
`define SMWC_HB_BIT      7
`define SMWC_ADDR_MSB    6
`define SMWC_ADDR_LSB    4

// ************************************************************
// Command addresses and data fields
// ************************************************************
`define SMWC_ADDR_OUT    3'h0
`define SMWC_ADDR_OCL    3'h1
`define SMWC_ADDR_OCH    3'h2
`define SMWC_ADDR_WDC    3'h3
`define SMWC_OUT_ON_BIT  0
`define SMWC_OCL_MSB     2
`define SMWC_OCH_LVL_BIT 0
`define SMWC_OCT_MSB     2
`define SMWC_OCT_LSB     1
`define SMWC_WD_DIS_BIT  3
`define SMWC_WD_SEL_MSB  1

// ************************************************************
// Reset and default values
// ************************************************************
`define SMWC_OCL_DEF     3'h7
`define SMWC_OCH_DEF     1'h1
`define SMWC_OCT_DEF     2'h0

// ************************************************************
// Synchronised pin vector
// ************************************************************
`define SMWC_PIN_N       10
`define SMWC_PIN_IDLE    10'h001
`define SMWC_PIN_CS      0
`define SMWC_PIN_SCLK    1
`define SMWC_PIN_SI      2
`define SMWC_PIN_WAKE    3
`define SMWC_PIN_RSTN    4
`define SMWC_PIN_FSG     5
`define SMWC_PIN_FSON    6
`define SMWC_PIN_VDD     7
`define SMWC_PIN_BATT    8
`define SMWC_PIN_FLT     9

// ************************************************************
// Watchdog timing
// ************************************************************
`define SMWC_REF_PERIOD_NS 50
`define SMWC_OSC_PERIOD_NS 1000
`define SMWC_WD_BASE_TICKS 10000
`define SMWC_WD_CNT_W      24
`define SMWC_DIV_W         16

`endif

// ===== smwc_pkg.sv
// Types shared by the mode, serial and watchdog control
package smwc_pkg;
   typedef enum logic [1:0] {
      MODE_SLEEP,
      MODE_NORMAL,
      MODE_FAULT,
      MODE_FAILSAFE
   } smwc_mode_e;
endpackage

// ===== smwc_wd_if.sv
// Link between the mode controller and its watchdog timer
interface smwc_wd_if #(parameter int SEL_W = 2);
   logic             run;
   logic             restart;
   logic [SEL_W-1:0] period_sel;
   logic             expired;
   modport ctl (output run, output restart, output period_sel, input expired);
   modport tmr (input run, input restart, input period_sel, output expired);
endinterface

// ===== smwc_wdog.sv
// Watchdog timer counting internal oscillator ticks
`include "smwc_defs.svh"
module smwc_wdog
   import smwc_pkg::*;
#(
   parameter int OSC_DIV    = `SMWC_OSC_PERIOD_NS / `SMWC_REF_PERIOD_NS,
   parameter int BASE_TICKS = `SMWC_WD_BASE_TICKS
) (
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   // Controller side
   smwc_wd_if.tmr    wd
);

   logic [`SMWC_DIV_W-1:0]    div_r;
   logic                      osc_tick_r;
   logic [`SMWC_WD_CNT_W-1:0] tick_cnt_r;
   logic                      expired_r;
   logic [`SMWC_WD_CNT_W-1:0] limit_w;

   // Period is the base tick count scaled by a power of two
   assign limit_w = `SMWC_WD_CNT_W'(BASE_TICKS) << wd.period_sel;

   // Oscillator model divided down from the reference clock
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || !wd.run) begin
         div_r      <= '0;
         osc_tick_r <= 1'h0;
      end else if (div_r == `SMWC_DIV_W'(OSC_DIV - 1)) begin
         div_r      <= '0;
         osc_tick_r <= 1'h1;
      end else begin
         div_r      <= div_r + 1'h1;
         osc_tick_r <= 1'h0;
      end
   end

   // Timeout counter; restart wins over a tick in the same cycle
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || !wd.run || wd.restart) begin
         tick_cnt_r <= '0;
         expired_r  <= 1'h0;
      // Compare is at or above so a shorter period chosen mid-count still expires
      end else if (osc_tick_r && (tick_cnt_r >= limit_w - 1'h1)) begin
         tick_cnt_r <= '0;
         expired_r  <= 1'h1;
      end else begin
         if (osc_tick_r) begin
            tick_cnt_r <= tick_cnt_r + 1'h1;
         end
         expired_r <= 1'h0;
      end
   end

   assign wd.expired = expired_r;

endmodule

// ===== smwc_ctrl.sv
// Top of the power switch serial command, mode and watchdog control
`include "smwc_defs.svh"

module smwc_ctrl
   import smwc_pkg::*;
#(
   parameter int OSC_DIV       = `SMWC_OSC_PERIOD_NS / `SMWC_REF_PERIOD_NS,
   parameter int WD_BASE_TICKS = `SMWC_WD_BASE_TICKS
) (
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   // Serial command link
   input  wire logic       cs_n_i,
   input  wire logic       sclk_i,
   input  wire logic       si_i,
   output logic            so_o,
   output logic            so_oe_o,
   // Mode pins and supply status
   input  wire logic       wake_i,
   input  wire logic       reset_n_i,
   input  wire logic       failsafe_select_gnd_i,
   input  wire logic       failsafe_select_on_i,
   input  wire logic       vdd_ok_i,
   input  wire logic       battery_supply_ok_i,
   input  wire logic       fault_detect_i,
   // Load and fault flag
   output logic            load_output_o,
   output logic            fault_flag_pin_o,
   output logic            fault_flag_pin_oe_o,
   // Status and configuration
   output logic [1:0]      mode_o,
   output logic            timeout_flag_o,
   output logic            wd_running_o,
   output logic [2:0]      overcurrent_low_level_o,
   output logic            overcurrent_high_level_o,
   output logic [1:0]      overcurrent_low_timing_o,
   output logic [1:0]      wd_period_sel_o
);

   // ************************************************************
   // Declarations
   // ************************************************************
   localparam logic [`SMWC_PIN_N-1:0] PIN_IDLE = `SMWC_PIN_IDLE;

   logic [`SMWC_PIN_N-1:0] pin_raw;
   logic [`SMWC_PIN_N-1:0] pin_meta_r;
   logic [`SMWC_PIN_N-1:0] pin_sync_r;
   logic [`SMWC_PIN_N-1:0] pin_dly_r;
   logic                   cs_n_s;
   logic                   sclk_s;
   logic                   si_s;
   logic                   wake_s;
   logic                   reset_n_s;
   logic                   fsg_s;
   logic                   fson_s;
   logic                   vdd_s;
   logic                   batt_s;
   logic                   flt_s;
   logic                   sclk_rise;
   logic                   cs_fall;
   logic                   cs_rise;
   logic                   wake_rise;
   logic                   rstn_rise;
   logic                   both_fall;
   logic                   sleep_pins;
   logic                   fault_any;
   logic [7:0]             shift_r;
   logic [3:0]             bit_cnt_r;
   logic                   so_r;
   logic                   so_oe_r;
   logic                   frame_done;
   logic [7:0]             reply_w;
   logic                   hb_prev_r;
   logic                   hb_restart_r;
   logic                   out_on_r;
   logic [2:0]             ocl_r;
   logic                   och_r;
   logic [1:0]             oct_r;
   logic                   wd_dis_r;
   logic [1:0]             wd_sel_r;
   logic                   clear_cfg;
   logic                   flt_seen_r;
   logic                   armed_r;
   logic                   wd_run_r;
   logic                   fs_latch_r;
   logic                   fs_enter;
   smwc_mode_e             mode_r;
   smwc_mode_e             mode_nxt;
   logic                   load_r;
   logic                   ffp_oe_r;
   logic                   ffp_r;
   logic                   timeout_r;

   smwc_wd_if #(.SEL_W(2)) wd_if ();

   // True when a completed frame writes the given address
   function automatic logic is_write(input logic done, input logic [7:0] cmd,
                                     input logic [2:0] addr);
      is_write = done && (cmd[`SMWC_ADDR_MSB:`SMWC_ADDR_LSB] == addr);
   endfunction

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   assign pin_raw = {fault_detect_i, battery_supply_ok_i, vdd_ok_i,
                     failsafe_select_on_i, failsafe_select_gnd_i, reset_n_i,
                     wake_i, si_i, sclk_i, cs_n_i};

   // Three flops per pin; the delayed copy reads only the second stage
   generate
      for (genvar g = 0; g < `SMWC_PIN_N; g++) begin : g_sync
         always_ff @(posedge ref_clk_i) begin
            if (rst_i) begin
               pin_meta_r[g] <= PIN_IDLE[g];
               pin_sync_r[g] <= PIN_IDLE[g];
               pin_dly_r[g]  <= PIN_IDLE[g];
            end else begin
               pin_meta_r[g] <= pin_raw[g];
               pin_sync_r[g] <= pin_meta_r[g];
               pin_dly_r[g]  <= pin_sync_r[g];
            end
         end
      end
   endgenerate

   // Named views of the synchronised pins
   assign cs_n_s    = pin_sync_r[`SMWC_PIN_CS];
   assign sclk_s    = pin_sync_r[`SMWC_PIN_SCLK];
   assign si_s      = pin_sync_r[`SMWC_PIN_SI];
   assign wake_s    = pin_sync_r[`SMWC_PIN_WAKE];
   assign reset_n_s = pin_sync_r[`SMWC_PIN_RSTN];
   assign fsg_s     = pin_sync_r[`SMWC_PIN_FSG];
   assign fson_s    = pin_sync_r[`SMWC_PIN_FSON];
   assign vdd_s     = pin_sync_r[`SMWC_PIN_VDD];
   assign batt_s    = pin_sync_r[`SMWC_PIN_BATT];
   assign flt_s     = pin_sync_r[`SMWC_PIN_FLT];

   // Edge events on the synchronised pins
   assign sclk_rise  = sclk_s & ~pin_dly_r[`SMWC_PIN_SCLK];
   assign cs_fall    = ~cs_n_s & pin_dly_r[`SMWC_PIN_CS];
   assign cs_rise    = cs_n_s & ~pin_dly_r[`SMWC_PIN_CS];
   assign wake_rise  = wake_s & ~pin_dly_r[`SMWC_PIN_WAKE];
   assign rstn_rise  = reset_n_s & ~pin_dly_r[`SMWC_PIN_RSTN];
   // Both must drop in the same sample to count as together
   assign both_fall  = pin_dly_r[`SMWC_PIN_WAKE] & pin_dly_r[`SMWC_PIN_RSTN]
                       & ~wake_s & ~reset_n_s;
   assign sleep_pins = ~wake_s & ~reset_n_s;
   // Low battery is treated as a fault
   assign fault_any  = flt_s | ~batt_s;

   // ************************************************************
   // Serial shifter
   // ************************************************************
   // Reply loaded at select: mode, fault seen, select state, timer config
   assign reply_w = {mode_r, flt_seen_r, fsg_s, hb_prev_r, timeout_r, wd_sel_r};

   always_ff @(posedge ref_clk_i) begin
      if (rst_i || !vdd_s) begin
         shift_r   <= '0;
         bit_cnt_r <= '0;
      end else if (cs_fall) begin
         shift_r   <= reply_w;
         bit_cnt_r <= '0;
      end else if (!cs_n_s && sclk_rise) begin
         shift_r <= {shift_r[6:0], si_s};
         if (bit_cnt_r != `SMWC_BITCNT_MAX) begin
            bit_cnt_r <= bit_cnt_r + 1'h1;
         end
      end
   end

   // incoming bits pass out behind the reply
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || !vdd_s) begin
         so_r    <= 1'h0;
         so_oe_r <= 1'h0;
      end else begin
         so_oe_r <= ~cs_n_s;
         if (cs_fall) begin
            so_r <= reply_w[7];
         end else if (!cs_n_s && sclk_rise) begin
            so_r <= shift_r[6];
         end
      end
   end

   // commit on deselect; longer chains keep the last eight bits
   assign frame_done = cs_rise && vdd_s && (bit_cnt_r >= `SMWC_FRAME_BITS);

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         hb_prev_r    <= 1'h0;
         hb_restart_r <= 1'h0;
      end else begin
         hb_restart_r <= frame_done && (shift_r[`SMWC_HB_BIT] != hb_prev_r);
         if (frame_done) begin
            hb_prev_r <= shift_r[`SMWC_HB_BIT];
         end
      end
   end

   // ************************************************************
   // Configuration registers
   // ************************************************************
   // supply loss clears
   assign clear_cfg = !vdd_s || !reset_n_s || (mode_r == MODE_SLEEP);

   // load command and watchdog setup over the serial link
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || clear_cfg) begin
         out_on_r <= 1'h0;
         wd_dis_r <= 1'h0;
         wd_sel_r <= 2'h0;
      end else begin
         if (is_write(frame_done, shift_r, `SMWC_ADDR_OUT)) begin
            out_on_r <= shift_r[`SMWC_OUT_ON_BIT];
         end
         if (is_write(frame_done, shift_r, `SMWC_ADDR_WDC)) begin
            wd_dis_r <= shift_r[`SMWC_WD_DIS_BIT];
            wd_sel_r <= shift_r[`SMWC_WD_SEL_MSB:0];
         end
      end
   end

   // overcurrent settings back to defaults on fail-safe entry
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || clear_cfg || fs_enter) begin
         ocl_r <= `SMWC_OCL_DEF;
         och_r <= `SMWC_OCH_DEF;
         oct_r <= `SMWC_OCT_DEF;
      end else begin
         if (is_write(frame_done, shift_r, `SMWC_ADDR_OCL)) begin
            ocl_r <= shift_r[`SMWC_OCL_MSB:0];
         end
         if (is_write(frame_done, shift_r, `SMWC_ADDR_OCH)) begin
            och_r <= shift_r[`SMWC_OCH_LVL_BIT];
            oct_r <= shift_r[`SMWC_OCT_MSB:`SMWC_OCT_LSB];
         end
      end
   end

   // Sticky fault seen; a read clears it but a new fault wins
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || !reset_n_s || !vdd_s) begin
         flt_seen_r <= 1'h0;
      end else if (fault_any) begin
         flt_seen_r <= 1'h1;
      end else if (frame_done) begin
         flt_seen_r <= 1'h0;
      end
   end

   // ************************************************************
   // Watchdog control
   // ************************************************************
   // arm on wake or reset rise
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || fsg_s || sleep_pins || fs_latch_r) begin
         armed_r <= 1'h0;
      end else if (wake_rise || rstn_rise) begin
         armed_r <= 1'h1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         wd_run_r <= 1'h0;
      end else begin
         wd_run_r <= armed_r & ~wd_dis_r & ~fsg_s & ~fs_latch_r
                     & (wake_s | reset_n_s);
      end
   end

   // period chosen by the timer config register
   assign wd_if.run        = wd_run_r;
   assign wd_if.restart    = hb_restart_r;
   assign wd_if.period_sel = wd_sel_r;

   smwc_wdog #(
      .OSC_DIV    (OSC_DIV),
      .BASE_TICKS (WD_BASE_TICKS)
   ) u_wdog (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .wd        (wd_if.tmr)
   );

   assign fs_enter = wd_if.expired & wd_run_r & ~fsg_s & ~fs_latch_r;

   // exit on joint fall or grounded select
   // Expiry beats a joint fall seen in the same cycle
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || fsg_s) begin
         fs_latch_r <= 1'h0;
      end else if (fs_enter) begin
         fs_latch_r <= 1'h1;
      end else if (both_fall) begin
         fs_latch_r <= 1'h0;
      end
   end

   // ************************************************************
   // Operating mode
   // ************************************************************
   // four modes, sleep when both inputs low unless fail-safe is latched
   // normal needs reset high and no fault
   always_comb begin
      if (fs_latch_r) begin
         mode_nxt = MODE_FAILSAFE;
      end else if (sleep_pins) begin
         mode_nxt = MODE_SLEEP;
      end else if (fault_any) begin
         mode_nxt = MODE_FAULT;
      end else if (reset_n_s) begin
         mode_nxt = MODE_NORMAL;
      end else begin
         mode_nxt = MODE_SLEEP;
      end
   end

   // Mode, load and flag registered together so outputs stay aligned
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         mode_r    <= MODE_SLEEP;
         load_r    <= 1'h0;
         ffp_oe_r  <= 1'h0;
         ffp_r     <= 1'h0;
         timeout_r <= 1'h0;
      end else begin
         mode_r    <= mode_nxt;
         ffp_r     <= 1'h0;
         // open drain, enable means pulling low
         ffp_oe_r  <= (mode_nxt == MODE_FAULT);
         timeout_r <= (mode_nxt == MODE_FAILSAFE);
         unique case (mode_nxt)
            MODE_SLEEP:    load_r <= 1'h0;
            MODE_NORMAL:   load_r <= out_on_r & ~clear_cfg;
            MODE_FAULT:    load_r <= 1'h0;
            MODE_FAILSAFE: load_r <= fson_s;
         endcase
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign so_o                     = so_r;
   assign so_oe_o                  = so_oe_r;
   assign load_output_o            = load_r;
   assign fault_flag_pin_o         = ffp_r;
   assign fault_flag_pin_oe_o      = ffp_oe_r;
   assign mode_o                   = mode_r;
   assign timeout_flag_o           = timeout_r;
   assign wd_running_o             = wd_run_r;
   assign overcurrent_low_level_o  = ocl_r;
   assign overcurrent_high_level_o = och_r;
   assign overcurrent_low_timing_o = oct_r;
   assign wd_period_sel_o          = wd_sel_r;

endmodule

// ===== smwc_ctrl_chk.sv
// Concurrent checks on the switch serial, mode and watchdog control ports
module smwc_ctrl_chk (
   // Clock and reset
   input wire logic       ref_clk_i,
   input wire logic       rst_i,
   // Serial link
   input wire logic       cs_n_i,
   input wire logic       sclk_i,
   input wire logic       so_o,
   input wire logic       so_oe_o,
   // Mode pins
   input wire logic       wake_i,
   input wire logic       reset_n_i,
   input wire logic       failsafe_select_gnd_i,
   input wire logic       failsafe_select_on_i,
   input wire logic       vdd_ok_i,
   // Outputs
   input wire logic       load_output_o,
   input wire logic       fault_flag_pin_oe_o,
   input wire logic [1:0] mode_o,
   input wire logic       timeout_flag_o,
   input wire logic       wd_running_o,
   input wire logic [2:0] overcurrent_low_level_o,
   input wire logic       overcurrent_high_level_o
);
   // Repeat counts cover the synchroniser lag of the pins
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   // ***
   // Serial link
   // ***
   oe_idle_a: assert property (cs_n_i [*5] |-> !so_oe_o)
      else $error("output driven while deselected");
   oe_on_a: assert property ((!cs_n_i && vdd_ok_i) [*6] |-> so_oe_o)
      else $error("output not driven while selected");
   so_edge_a: assert property (so_oe_o && $past(so_oe_o) && $changed(so_o) |->
      $past(sclk_i, 3) || $past(sclk_i, 4)) else $error("output bit moved off clock rise");
   // ***
   // Modes
   // ***
   sleep_pins_a: assert property ((!wake_i && !reset_n_i && mode_o != 2'h3) [*6]
      |-> mode_o == 2'h0) else $error("not asleep with both pins low");
   sleep_off_a: assert property ((mode_o == 2'h0) [*2] |-> !load_output_o)
      else $error("load on in sleep");
   fault_flag_a: assert property ((mode_o == 2'h2) [*2] |->
      fault_flag_pin_oe_o && !load_output_o) else $error("fault mode flag or load wrong");
   tflag_fs_a: assert property ((mode_o == 2'h3) [*2] |-> timeout_flag_o)
      else $error("timeout flag low in fail-safe");
   fs_load_a: assert property ((mode_o == 2'h3 && $stable(failsafe_select_on_i)) [*6]
      |-> load_output_o == failsafe_select_on_i) else $error("fail-safe load wrong");
   fs_dflt_a: assert property ($rose(mode_o == 2'h3) |-> ##[0:2]
      (overcurrent_low_level_o == 3'h7 && overcurrent_high_level_o))
      else $error("overcurrent defaults not restored");
   gnd_block_a: assert property (failsafe_select_gnd_i [*8] |->
      mode_o != 2'h3 && !wd_running_o) else $error("grounded select ignored");
endmodule

bind smwc_ctrl smwc_ctrl_chk u_chk (
   .ref_clk_i, .rst_i, .cs_n_i, .sclk_i, .so_o, .so_oe_o, .wake_i, .reset_n_i,
   .failsafe_select_gnd_i, .failsafe_select_on_i, .vdd_ok_i, .load_output_o,
   .fault_flag_pin_oe_o, .mode_o, .timeout_flag_o, .wd_running_o,
   .overcurrent_low_level_o, .overcurrent_high_level_o
);

// ===== smwc_spi_master.sv
// Serial master model for the switch command link
module smwc_spi_master (
   // Clock
   input  wire logic ref_clk_i,
   // Link pins
   output logic      cs_n_o,
   output logic      sclk_o,
   output logic      si_o,
   input  wire logic so_i
);
   timeunit 1ns;
   timeprecision 1ns;
   int hp = 4;  // Half period in ticks; raise it for a slow master
   // Idle link: select pulled up, clock and data pulled down
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      si_o   = 1'b0;
   end
   // ***
   // Transfer
   // ***
   // even clock, MSB first, data set well ahead
   task automatic xfer(input int n, input logic [15:0] d, input bit sel,
                       output logic [15:0] q);
      q = 16'h0000;
      cs_n_o = !sel;
      repeat (hp) @(negedge ref_clk_i);
      for (int i = n - 1; i >= 0; i--) begin
         si_o = d[i];
         repeat (hp) @(negedge ref_clk_i);
         q = {q[14:0], so_i};
         sclk_o = 1'b1;
         repeat (hp) @(negedge ref_clk_i);
         sclk_o = 1'b0;
      end
      repeat (2) @(negedge ref_clk_i);
      cs_n_o = 1'b1;
      si_o   = 1'b0;
      repeat (8) @(negedge ref_clk_i);
   endtask
endmodule

// ===== testbench.sv
// Self-checking bench for the switch serial, mode and watchdog control
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk = 1'b0, rst = 1'b1, hb = 1'b0;
   logic       cs_n, sclk, si, so, so_oe, so_line, flag, flag_oe, flag_line;
   logic       wake = 1'b0, reset_n = 1'b0, fs_gnd = 1'b0, fs_on = 1'b1;
   logic       vdd_ok = 1'b1, batt_ok = 1'b1, fault_det = 1'b0;
   logic       load, tflag, wd_run, och;
   logic [1:0] mode, oct, sel;
   logic [2:0] ocl;
   int         fail_count = 0, checks_done = 0, seed = 32'hbf02;
   int         e_mode, e_on, e_ocl, e_och, e_oct, e_sel;
   // 20 MHz clock
   always #25 clk = !clk;
   // Released output shows the inverse; flag line has a pull-up
   assign so_line   = so_oe ? so : !so;
   assign flag_line = flag_oe ? flag : 1'b1;
   smwc_ctrl #(.OSC_DIV(2), .WD_BASE_TICKS(200)) DUT (
      .ref_clk_i(clk), .rst_i(rst), .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si), .so_o(so),
      .so_oe_o(so_oe), .wake_i(wake), .reset_n_i(reset_n), .failsafe_select_gnd_i(fs_gnd),
      .failsafe_select_on_i(fs_on), .vdd_ok_i(vdd_ok), .battery_supply_ok_i(batt_ok),
      .fault_detect_i(fault_det), .load_output_o(load), .fault_flag_pin_o(flag),
      .fault_flag_pin_oe_o(flag_oe), .mode_o(mode), .timeout_flag_o(tflag),
      .wd_running_o(wd_run), .overcurrent_low_level_o(ocl), .overcurrent_high_level_o(och),
      .overcurrent_low_timing_o(oct), .wd_period_sel_o(sel));
   smwc_spi_master master (.ref_clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si),
      .so_i(so_line));
   // ***
   // Checking tasks
   // ***
   task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wrap_up();
      if (fail_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check_all();
      check("mode", 8'(mode), 8'(e_mode));
      check("load", 8'(load), 8'(e_mode == 3 ? fs_on : (e_mode == 1 ? e_on : 0)));
      check("ocl", 8'(ocl), 8'(e_ocl));
      check("och", 8'(och), 8'(e_och));
      check("oct", 8'(oct), 8'(e_oct));
      check("sel", 8'(sel), 8'(e_sel));
      check("tflag", 8'(tflag), 8'(e_mode == 3));
      check("flag", 8'(flag_line), 8'(e_mode != 2));
   endtask
   // Bounded wait for a mode, then the model follows it
   task automatic wait_mode(input int m);
      int n;
      n = 0;
      while (mode !== 2'(m) && n < 1500) begin
         @(negedge clk);
         n++;
      end
      if (mode !== 2'(m)) begin
         check("mode_wait", 8'(mode), 8'(m));
         wrap_up();
      end else begin
         e_mode = m;
         // Sleep clears config; overcurrent settings sit at their reset values
         if (m == 0) {e_on, e_sel} = '0;
         if (m == 0 || m == 3) {e_ocl, e_och, e_oct} = {32'd7, 32'd1, 32'd0};
         repeat (4) @(negedge clk);
      end
   endtask
   // Two-byte chain frame: random lead byte, then the command
   task automatic send(input logic [6:0] body);
      logic [15:0] q;
      logic [7:0]  lead;
      lead = 8'($random(seed));
      // heartbeat toggles in every counted frame
      hb = !hb;
      master.xfer(16, {lead, hb, body}, 1'b1, q);
      check("reply", q[15:8] & 8'hDF, {e_mode[1:0], 1'b0, fs_gnd, !hb, e_mode == 3, e_sel[1:0]});
      check("chain", q[7:0], lead);
      case (body[6:4])
         3'h0: e_on = body[0];
         3'h1: e_ocl = body[2:0];
         3'h2: {e_oct, e_och} = {30'd0, body[2:1], 31'd0, body[0]};
         3'h3: e_sel = body[1:0];
         default: ;
      endcase
   endtask
   // Main sequence
   initial begin
      logic [15:0] q;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      wait_mode(0);
      check_all();
      reset_n = 1'b1;
      wait_mode(1);
      // Random writes over the first three addresses, then a period select
      for (int i = 0; i < 9; i++) begin
         send({3'(i % 3), 4'($random(seed))});
         if (i > 1) check_all();
      end
      send(7'h31);
      master.hp = 6;
      send(7'h01);
      master.hp = 4;
      // Disable bit stops the watchdog, clearing it lets it run again
      send(7'h39);
      check("wd_run", 8'(wd_run), 8'h00);
      send(7'h31);
      check("wd_run", 8'(wd_run), 8'h01);
      check_all();
      // short frame and deselected clocking are both ignored
      master.xfer(7, 16'h0000, 1'b1, q);
      master.xfer(8, {8'h00, !hb, 7'h00}, 1'b0, q);
      check_all();
      // detector, then low battery, each force fault mode
      for (int k = 0; k < 2; k++) begin
         fault_det = (k == 0);
         batt_ok = fault_det;
         wait_mode(2);
         check_all();
         {fault_det, batt_ok} = 2'b01;
         wait_mode(1);
         check_all();
      end
      // logic supply loss returns config to reset values
      vdd_ok = 1'b0;
      repeat (8) @(negedge clk);
      vdd_ok = 1'b1;
      {e_on, e_sel} = '0;
      {e_ocl, e_och, e_oct} = {32'd7, 32'd1, 32'd0};
      repeat (8) @(negedge clk);
      check_all();
      // heartbeat stops, fail-safe latches and follows select
      wait_mode(3);
      check_all();
      fs_on = 1'b0;
      wake = 1'b1;
      repeat (8) @(negedge clk);
      check_all();
      // both pins dropped together leave fail-safe
      {wake, reset_n} = 2'b00;
      wait_mode(0);
      check_all();
      // wake alone arms the watchdog with reset low
      wake = 1'b1;
      repeat (8) @(negedge clk);
      check("wd_run", 8'(wd_run), 8'h01);
      wait_mode(3);
      check_all();
      // Grounded select ends fail-safe and stops the watchdog
      fs_gnd = 1'b1;
      wait_mode(0);
      check_all();
      check("wd_run", 8'(wd_run), 8'h00);
      wrap_up();
   end
endmodule
